// [src/tatu_xlat_unit.sv]
`timescale 1ns/1ps
module tatu_xlat_unit
   import tatu_pkg::*;
#(
   parameter bit SMALL_PAGE_SUPPORT = 1'b0
)(
   input  wire logic                clk_sys,
   input  wire logic                sys_rst,
   input  wire tatu_mode_type       cur_mode,
   input  wire logic [ASID_W-1:0]   current_entry_high_asid,
   input  wire logic                page_granularity_config,
   input  wire logic                fetch_req,
   input  wire logic [VA_W-1:0]     fetch_va,
   output logic                     fetch_ready,
   output logic                     fetch_done_reg,
   output logic [VA_W-1:0]          fetch_pa_reg,
   output logic                     fetch_uncached_reg,
   output logic                     fetch_to_debug_reg,
   output logic                     fetch_refill_reg,
   input  wire logic                data_req,
   input  wire logic [VA_W-1:0]     data_va,
   output logic                     data_ready,
   output logic                     data_done_reg,
   output logic [VA_W-1:0]          data_pa_reg,
   output logic                     data_uncached_reg,
   output logic                     data_to_debug_reg,
   output logic                     data_refill_reg,
   input  wire logic                jw_req,
   input  wire logic [JB_IDX_W-1:0] jw_index,
   input  wire logic [VPN2_W-1:0]   jw_vpn2,
   input  wire logic [MASK_W-1:0]   jw_mask,
   input  wire logic [ASID_W-1:0]   jw_asid,
   input  wire logic                jw_global,
   input  wire logic [PFN_W-1:0]    jw_pfn_even,
   input  wire logic [PFN_W-1:0]    jw_pfn_odd,
   output logic                     machine_check_reg
);

   logic                small_pages;
   logic [JB_PAIRS-1:0] jb_valid_reg, jb_valid_next;
   logic [VPN2_W-1:0]   jb_vpn2_reg [JB_PAIRS];
   logic [MASK_W-1:0]   jb_mask_reg [JB_PAIRS];
   logic [ASID_W-1:0]   jb_asid_reg [JB_PAIRS];
   logic [JB_PAIRS-1:0] jb_glob_reg;
   logic [PFN_W-1:0]    jb_even_reg [JB_PAIRS];
   logic [PFN_W-1:0]    jb_odd_reg  [JB_PAIRS];
   logic [JB_PAIRS-1:0] f_hit_v, f_odd_v, d_hit_v, d_odd_v, w_hit_v;
   logic [VA_W-1:0]     f_off_v [JB_PAIRS];
   logic [VA_W-1:0]     d_off_v [JB_PAIRS];
   logic                w_conflict, mc_next;
   logic                fj_hit, dj_hit;
   logic [VA_W-1:0]     fj_pa, dj_pa;
   logic [VA_W-1:0]     fva_reg, fva_next;

   // all checks run on the core clock and rest while reset is held
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // 1 Kbyte pages only when built in and enabled by the granularity setting
   assign small_pages = SMALL_PAGE_SUPPORT && page_granularity_config;

   // three comparators per pair: fetch lookup, data lookup, write compare
   for (genvar p = 0; p < JB_PAIRS; p++) begin : g_pair
      tatu_pair_match u_fmatch (
         .entry_valid(jb_valid_reg[p]), .entry_vpn2(jb_vpn2_reg[p]),
         .entry_mask(jb_mask_reg[p]), .entry_global(jb_glob_reg[p]),
         .entry_asid(jb_asid_reg[p]), .small_pages(small_pages),
         .look_va(fva_reg), .look_asid(current_entry_high_asid),
         .hit(f_hit_v[p]), .odd(f_odd_v[p]), .offset_mask(f_off_v[p]));
      tatu_pair_match u_dmatch (
         .entry_valid(jb_valid_reg[p]), .entry_vpn2(jb_vpn2_reg[p]),
         .entry_mask(jb_mask_reg[p]), .entry_global(jb_glob_reg[p]),
         .entry_asid(jb_asid_reg[p]), .small_pages(small_pages),
         .look_va(data_va), .look_asid(current_entry_high_asid),
         .hit(d_hit_v[p]), .odd(d_odd_v[p]), .offset_mask(d_off_v[p]));
      tatu_pair_match u_wmatch (
         .entry_valid(jb_valid_reg[p] && (jw_index != JB_IDX_W'(p))),
         .entry_vpn2(jb_vpn2_reg[p]), .entry_mask(jb_mask_reg[p] | jw_mask),
         .entry_global(jb_glob_reg[p] || jw_global), .entry_asid(jb_asid_reg[p]),
         .small_pages(small_pages), .look_va({jw_vpn2, 11'h000}),
         .look_asid(jw_asid), .hit(w_hit_v[p]), .odd(), .offset_mask());
   end

   // frame of the hitting pair merged with the page offset
   always_comb begin
      fj_hit = |f_hit_v;
      dj_hit = |d_hit_v;
      fj_pa  = 32'h00000000;
      dj_pa  = 32'h00000000;
      for (int p = 0; p < JB_PAIRS; p++) begin
         if (f_hit_v[p]) begin
            fj_pa = ({f_odd_v[p] ? jb_odd_reg[p] : jb_even_reg[p], 10'h000} & ~f_off_v[p])
                    | (fva_reg & f_off_v[p]);
         end
         if (d_hit_v[p]) begin
            dj_pa = ({d_odd_v[p] ? jb_odd_reg[p] : jb_even_reg[p], 10'h000} & ~d_off_v[p])
                    | (data_va & d_off_v[p]);
         end
      end
   end

   // a write that overlaps another pair is dropped
   always_comb begin
      w_conflict    = |w_hit_v;
      jb_valid_next = jb_valid_reg;
      mc_next       = 1'b0;
      if (jw_req) begin
         if (w_conflict) begin
            mc_next = 1'b1;
         end else begin
            jb_valid_next[jw_index] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         jb_valid_reg      <= JB_VALID_RST;
         machine_check_reg <= 1'b0;
      end else begin
         jb_valid_reg      <= jb_valid_next;
         machine_check_reg <= mc_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (jw_req && !w_conflict) begin
         jb_vpn2_reg[jw_index] <= jw_vpn2;
         jb_mask_reg[jw_index] <= jw_mask;
         jb_asid_reg[jw_index] <= jw_asid;
         jb_glob_reg[jw_index] <= jw_global;
         jb_even_reg[jw_index] <= jw_pfn_even;
         jb_odd_reg[jw_index]  <= jw_pfn_odd;
      end
   end

   // fixed segment decode shared by both paths
   function automatic logic seg_mapped(input logic [VA_W-1:0] va);
      seg_mapped = !va[31] || (va[31:30] == 2'h3);
   endfunction

   function automatic logic seg_debug(input logic [VA_W-1:0] va, input tatu_mode_type m);
      seg_debug = (m == MODE_DEBUG)
                  && (va >= DEBUG_WIN_LO) && (va <= DEBUG_WIN_HI);
   endfunction

   // fetch path
   tatu_fstate_type  fst_reg, fst_next;
   logic [VA_W-1:0]  fpa_reg, fpa_next;
   logic             f_fill, f_uhit, f_any, fdone_n, func_n, fdbg_n, frefill_n;
   logic [VA_W-1:0]  f_upa, fpa_out_n;
   logic             flush_ub;

   assign flush_ub    = jw_req && !w_conflict;
   assign fetch_ready = (fst_reg == F_IDLE);
   assign f_fill      = (fst_reg == F_FILL);

   tatu_micro_buf u_fetch_micro (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .flush(flush_ub), .small_pages(small_pages),
      .look_va(f_fill ? fva_reg : fetch_va), .look_asid(current_entry_high_asid),
      .hit(f_uhit), .pa(f_upa), .fill_en(f_fill), .fill_va(fva_reg),
      .fill_asid(current_entry_high_asid), .fill_global(1'b1), .fill_pa(fpa_reg),
      .any_valid(f_any));

   // hit answers next cycle; miss walks look then fill, or look then refill on a joint miss
   always_comb begin
      fst_next  = fst_reg;
      fva_next  = fva_reg;
      fpa_next  = fpa_reg;
      fdone_n   = 1'b0;
      func_n    = 1'b0;
      fdbg_n    = 1'b0;
      frefill_n = 1'b0;
      fpa_out_n = fetch_pa_reg;
      case (fst_reg)
         F_IDLE: begin
            if (fetch_req) begin
               fva_next = fetch_va;
               if (seg_debug(fetch_va, cur_mode) || !seg_mapped(fetch_va)) begin
                  fdone_n   = 1'b1;
                  fdbg_n    = seg_debug(fetch_va, cur_mode);
                  func_n    = (fetch_va[31:29] == SEG_UNMAP_UNCACHED);
                  fpa_out_n = fdbg_n ? fetch_va : (fetch_va & UNMAPPED_PA_MASK);
               end else if (f_uhit) begin
                  fdone_n   = 1'b1;
                  fpa_out_n = f_upa;
               end else begin
                  fst_next = F_LOOK;
               end
            end
         end
         F_LOOK: begin
            if (fj_hit) begin
               fpa_next = fj_pa;
               fst_next = F_FILL;
            end else begin
               frefill_n = 1'b1;
               fst_next  = F_IDLE;
            end
         end
         F_FILL: begin
            fdone_n   = 1'b1;
            fpa_out_n = fpa_reg;
            fst_next  = F_IDLE;
         end
         default: fst_next = F_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         fst_reg            <= F_IDLE;
         fva_reg            <= '0;
         fpa_reg            <= '0;
         fetch_done_reg     <= 1'b0;
         fetch_pa_reg       <= '0;
         fetch_uncached_reg <= 1'b0;
         fetch_to_debug_reg <= 1'b0;
         fetch_refill_reg   <= 1'b0;
      end else begin
         fst_reg            <= fst_next;
         fva_reg            <= fva_next;
         fpa_reg            <= fpa_next;
         fetch_done_reg     <= fdone_n;
         fetch_pa_reg       <= fpa_out_n;
         fetch_uncached_reg <= func_n;
         fetch_to_debug_reg <= fdbg_n;
         fetch_refill_reg   <= frefill_n;
      end
   end

   // data path: joint buffer consulted in the same cycle as the micro buffer
   tatu_dstate_type  dst_reg, dst_next;
   logic [VA_W-1:0]  dpa_reg, dpa_next;
   logic             d_fill, d_uhit, d_any, ddone_n, dunc_n, ddbg_n, drefill_n;
   logic [VA_W-1:0]  d_upa, dpa_out_n;

   assign data_ready = (dst_reg == D_IDLE);
   assign d_fill     = data_req && data_ready && seg_mapped(data_va)
                       && !seg_debug(data_va, cur_mode) && !d_uhit && dj_hit;

   tatu_micro_buf u_data_micro (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .flush(flush_ub), .small_pages(small_pages),
      .look_va(data_va), .look_asid(current_entry_high_asid), .hit(d_uhit), .pa(d_upa),
      .fill_en(d_fill), .fill_va(data_va), .fill_asid(current_entry_high_asid),
      .fill_global(1'b1), .fill_pa(dj_pa), .any_valid(d_any));

   always_comb begin
      dst_next  = dst_reg;
      dpa_next  = dpa_reg;
      ddone_n   = 1'b0;
      dunc_n    = 1'b0;
      ddbg_n    = 1'b0;
      drefill_n = 1'b0;
      dpa_out_n = data_pa_reg;
      case (dst_reg)
         D_IDLE: begin
            if (data_req) begin
               if (seg_debug(data_va, cur_mode) || !seg_mapped(data_va)) begin
                  ddone_n   = 1'b1;
                  ddbg_n    = seg_debug(data_va, cur_mode);
                  dunc_n    = (data_va[31:29] == SEG_UNMAP_UNCACHED);
                  dpa_out_n = ddbg_n ? data_va : (data_va & UNMAPPED_PA_MASK);
               end else if (d_uhit) begin
                  ddone_n   = 1'b1;
                  dpa_out_n = d_upa;
               end else if (dj_hit) begin
                  dpa_next = dj_pa;
                  dst_next = D_PEN;
               end else begin
                  drefill_n = 1'b1;
               end
            end
         end
         D_PEN: begin
            ddone_n   = 1'b1;
            dpa_out_n = dpa_reg;
            dst_next  = D_IDLE;
         end
         default: dst_next = D_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         dst_reg           <= D_IDLE;
         dpa_reg           <= '0;
         data_done_reg     <= 1'b0;
         data_pa_reg       <= '0;
         data_uncached_reg <= 1'b0;
         data_to_debug_reg <= 1'b0;
         data_refill_reg   <= 1'b0;
      end else begin
         dst_reg           <= dst_next;
         dpa_reg           <= dpa_next;
         data_done_reg     <= ddone_n;
         data_pa_reg       <= dpa_out_n;
         data_uncached_reg <= dunc_n;
         data_to_debug_reg <= ddbg_n;
         data_refill_reg   <= drefill_n;
      end
   end

   // checks

   AST_FETCH_MISS_PEN: assert property (
      (fst_reg == F_IDLE) && fetch_req && seg_mapped(fetch_va) && !seg_debug(fetch_va, cur_mode)
      && !f_uhit ##1 fj_hit |-> !fetch_done_reg ##1 !fetch_done_reg ##1 fetch_done_reg)
      else $error("fetch miss penalty wrong");
   AST_FETCH_LOOK_NEXT: assert property (
      fetch_req && fetch_ready && !fva_next[31] && !f_uhit |=> fst_reg == F_LOOK)
      else $error("fetch miss did not start joint lookup");
   AST_DATA_MISS_PEN: assert property (
      d_fill |=> !data_done_reg ##1 data_done_reg && (data_pa_reg == $past(dj_pa, 2)))
      else $error("data miss penalty wrong");
   AST_DATA_COPY: assert property (
      d_fill && !flush_ub |=> d_any)
      else $error("data translation not copied");
   AST_REFILL: assert property (
      (fst_reg == F_LOOK) && !fj_hit |=> fetch_refill_reg && !fetch_done_reg)
      else $error("missing refill exception");
   AST_FLUSH: assert property (
      flush_ub |=> !f_any && !d_any)
      else $error("micro buffers not flushed");
   AST_MCHECK: assert property (
      jw_req && w_conflict |=> machine_check_reg && (jb_valid_reg == $past(jb_valid_reg)))
      else $error("conflicting write not aborted");
   AST_UNCACHED: assert property (
      fetch_req && fetch_ready && (fetch_va[31:29] == SEG_UNMAP_UNCACHED)
      |=> fetch_done_reg && fetch_uncached_reg && (fetch_pa_reg[31:29] == 3'h0))
      else $error("uncached segment mishandled");
   AST_DEBUG_WIN: assert property (
      data_req && data_ready && (cur_mode != MODE_DEBUG) && (data_va >= DEBUG_WIN_LO)
      && (data_va <= DEBUG_WIN_HI) |=> !data_to_debug_reg)
      else $error("debug window routed outside debug mode");

   COV_FETCH_FILL: cover property (fst_reg == F_LOOK ##1 fst_reg == F_FILL);
   COV_DATA_FILL:  cover property (d_fill);
   COV_MCHECK:     cover property (machine_check_reg);

endmodule

// [inc/tatu_pkg.sv]
package tatu_pkg;

   // address and buffer geometry
   localparam int VA_W        = 32;
   localparam int JB_PAIRS    = 16;
   localparam int JB_IDX_W    = 4;
   localparam int UB_ENTRIES  = 4;
   localparam int UB_IDX_W    = 2;
   localparam int ASID_W      = 8;
   localparam int VPN2_W      = 21;   // virtual address bits 31:11
   localparam int VPN2_LSB    = 11;
   localparam int MASK_W      = 18;   // page mask bits 28:11
   localparam int PFN_W       = 22;   // physical frame, address bits 31:10
   localparam int PFN_LSB     = 10;
   localparam int UB_VPN_W    = 22;   // micro tag, address bits 31:10

   // mask bits forced on when the minimum page is 4 Kbytes
   localparam logic [MASK_W-1:0] MASK_LARGE_MIN = 18'h00003;

   // fixed segments, keyed by the top three address bits
   localparam logic [2:0]  SEG_UNMAP_CACHED   = 3'h4;
   localparam logic [2:0]  SEG_UNMAP_UNCACHED = 3'h5;
   localparam logic [31:0] UNMAPPED_PA_MASK   = 32'h1fffffff;
   localparam logic [31:0] DEBUG_WIN_LO       = 32'hff200000;
   localparam logic [31:0] DEBUG_WIN_HI       = 32'hff3fffff;

   // state after reset
   localparam logic [UB_ENTRIES-1:0] UB_VALID_RST = 4'h0;
   localparam logic [JB_PAIRS-1:0]   JB_VALID_RST = 16'h0000;

   typedef enum logic [1:0] {
      MODE_USER   = 2'h0,
      MODE_KERNEL = 2'h1,
      MODE_DEBUG  = 2'h2
   } tatu_mode_type;

   typedef enum logic [2:0] {
      F_IDLE = 3'h1,
      F_LOOK = 3'h2,
      F_FILL = 3'h4
   } tatu_fstate_type;

   typedef enum logic [1:0] {
      D_IDLE = 2'h1,
      D_PEN  = 2'h2
   } tatu_dstate_type;

endpackage

// [src/tatu_pair_match.sv]
`timescale 1ns/1ps
module tatu_pair_match
   import tatu_pkg::*;
(
   input  wire logic              entry_valid,
   input  wire logic [VPN2_W-1:0] entry_vpn2,
   input  wire logic [MASK_W-1:0] entry_mask,
   input  wire logic              entry_global,
   input  wire logic [ASID_W-1:0] entry_asid,
   input  wire logic              small_pages,
   input  wire logic [VA_W-1:0]   look_va,
   input  wire logic [ASID_W-1:0] look_asid,
   output logic                   hit,
   output logic                   odd,
   output logic [VA_W-1:0]        offset_mask
);

   logic [MASK_W-1:0] eff_mask;
   logic              vpn_eq;
   int                sel_bit;

   // compared bits and even/odd bit follow this pair's own mask
   always_comb begin
      eff_mask = small_pages ? entry_mask : (entry_mask | MASK_LARGE_MIN);
      vpn_eq   = 1'b1;
      sel_bit  = PFN_LSB;
      for (int i = 0; i < VPN2_W; i++) begin
         if ((i >= MASK_W) || !eff_mask[i]) begin
            if (entry_vpn2[i] != look_va[i+VPN2_LSB]) begin
               vpn_eq = 1'b0;
            end
         end
      end
      for (int i = 0; i < MASK_W; i++) begin
         if (eff_mask[i]) begin
            sel_bit = sel_bit + 1;
         end
      end
      for (int b = 0; b < VA_W; b++) begin
         offset_mask[b] = (b < sel_bit);
      end
      odd = look_va[sel_bit];
      hit = entry_valid && vpn_eq && (entry_global || (entry_asid == look_asid));
   end

endmodule

// [src/tatu_micro_buf.sv]
`timescale 1ns/1ps
module tatu_micro_buf
   import tatu_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic              flush,
   input  wire logic              small_pages,
   input  wire logic [VA_W-1:0]   look_va,
   input  wire logic [ASID_W-1:0] look_asid,
   output logic                   hit,
   output logic [VA_W-1:0]        pa,
   input  wire logic              fill_en,
   input  wire logic [VA_W-1:0]   fill_va,
   input  wire logic [ASID_W-1:0] fill_asid,
   input  wire logic              fill_global,
   input  wire logic [VA_W-1:0]   fill_pa,
   output logic                   any_valid
);

   logic [UB_ENTRIES-1:0] valid_reg, valid_next;
   logic [UB_IDX_W-1:0]   rr_reg, rr_next;
   logic [UB_IDX_W-1:0]   victim;
   logic                  have_free;
   logic [UB_VPN_W-1:0]   vpn_reg   [UB_ENTRIES];
   logic [UB_VPN_W-1:0]   ppn_reg   [UB_ENTRIES];
   logic [ASID_W-1:0]     asid_reg  [UB_ENTRIES];
   logic [UB_ENTRIES-1:0] glob_reg, small_reg;

   assign any_valid = |valid_reg;

   // lookup; 4 Kbyte entries ignore address bits 11:10 in compare and output
   always_comb begin
      hit = 1'b0;
      pa  = 32'h00000000;
      for (int i = 0; i < UB_ENTRIES; i++) begin
         if (valid_reg[i] && (vpn_reg[i][21:2] == look_va[31:12])
             && (!small_reg[i] || (vpn_reg[i][1:0] == look_va[11:10]))
             && (glob_reg[i] || (asid_reg[i] == look_asid))) begin
            hit = 1'b1;
            pa  = {ppn_reg[i][21:2], small_reg[i] ? ppn_reg[i][1:0] : look_va[11:10],
                   look_va[9:0]};
         end
      end
   end

   // free slot first, else round-robin victim once full
   always_comb begin
      have_free = 1'b0;
      victim    = rr_reg;
      for (int i = UB_ENTRIES - 1; i >= 0; i--) begin
         if (!valid_reg[i]) begin
            have_free = 1'b1;
            victim    = i[UB_IDX_W-1:0];
         end
      end
   end

   // flush wins over fill in the same cycle; a fetch fill the cycle after a joint write still copies the lookup made before it
   always_comb begin
      valid_next = valid_reg;
      rr_next    = rr_reg;
      if (flush) begin
         valid_next = UB_VALID_RST;
      end else if (fill_en) begin
         valid_next[victim] = 1'b1;
         if (!have_free) begin
            rr_next = rr_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         valid_reg <= UB_VALID_RST;
         rr_reg    <= '0;
      end else begin
         valid_reg <= valid_next;
         rr_reg    <= rr_next;
      end
   end

   // entry payload needs no reset, it is qualified by the valid bits
   always_ff @(posedge clk_sys) begin
      if (fill_en && !flush) begin
         vpn_reg[victim]   <= fill_va[31:10];
         ppn_reg[victim]   <= fill_pa[31:10];
         asid_reg[victim]  <= fill_asid;
         glob_reg[victim]  <= fill_global;
         small_reg[victim] <= small_pages;
      end
   end

endmodule

// [testbench/tatu_exec_port.sv]
`timescale 1ns/1ps
// execution-side requester for one translation port (fetch or load/store)
module tatu_exec_port
#(
   parameter bit HOLD_VA = 1'b1
)(
   input  wire logic        clk_sys,
   output logic             req,
   output logic [31:0]      va,
   input  wire logic        ready,
   input  wire logic        done,
   input  wire logic        refill,
   input  wire logic [31:0] pa
);
   initial begin
      req = 1'b0;
      va  = 32'h0;
   end
   // one request; n counts edges from the taking edge to the answer
   task automatic xlat(input logic [31:0] a, output logic [31:0] p, output logic rf,
                       output int n);
      n = 0;
      @(negedge clk_sys);
      while (ready !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      req = 1'b1;
      va  = a;
      n   = 0;
      do begin
         @(negedge clk_sys);
         req = 1'b0;
         if (!HOLD_VA) va = ~a;   // a released bus must not keep showing the old address
         n++;
      end while (done !== 1'b1 && refill !== 1'b1 && n < 20);
      if (HOLD_VA) va = ~a;
      p  = pa;
      rf = refill;
   endtask
endmodule

// [testbench/test_tlb_address_translation_unit.sv]
`timescale 1ns/1ps
module test_tlb_address_translation_unit;
   import tatu_pkg::*;
   logic clk_sys = 1'b0, sys_rst = 1'b1, page_granularity_config = 1'b0, jw_req = 1'b0;
   tatu_mode_type cur_mode = MODE_KERNEL;
   logic [7:0] current_entry_high_asid = 8'h05, jw_asid = 8'h00;
   logic [3:0] jw_index = 4'h0;
   logic [20:0] jw_vpn2 = 21'h0;
   logic [17:0] jw_mask = 18'h0;
   logic jw_global = 1'b0;
   logic [21:0] jw_pfn_even = 22'h0, jw_pfn_odd = 22'h0;
   logic fetch_req, fetch_ready, fetch_done_reg, fetch_uncached_reg, fetch_to_debug_reg;
   logic fetch_refill_reg, data_req, data_ready, data_done_reg, data_uncached_reg;
   logic data_to_debug_reg, data_refill_reg, machine_check_reg;
   logic [31:0] fetch_va, fetch_pa_reg, data_va, data_pa_reg;
   int fail_count = 0, comparisons = 0, cyc = 0;
   tatu_xlat_unit u_dut (.*);
   tatu_exec_port #(.HOLD_VA(1'b1)) u_fetch (.clk_sys(clk_sys), .req(fetch_req), .va(fetch_va),
      .ready(fetch_ready), .done(fetch_done_reg), .refill(fetch_refill_reg), .pa(fetch_pa_reg));
   tatu_exec_port #(.HOLD_VA(1'b0)) u_data (.clk_sys(clk_sys), .req(data_req), .va(data_va),
      .ready(data_ready), .done(data_done_reg), .refill(data_refill_reg), .pa(data_pa_reg));
   always #2.5 clk_sys = ~clk_sys;
   // hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one translation on fetch (d=0) or data (d=1): answer, latency, result
   task automatic x(input logic d, input logic [31:0] a, e, input int c, input logic erf);
      logic [31:0] p;
      logic rf;
      int n;
      if (d) u_data.xlat(a, p, rf, n);
      else u_fetch.xlat(a, p, rf, n);
      chk("refill", {31'h0, erf}, {31'h0, rf});
      chk("cycles", c, n);
      if (!erf) chk("pa", e, p);
   endtask
   // joint write; an overlap answer may land on either of the two following edges
   task automatic jw(input logic [3:0] i, input logic [20:0] v, input logic [17:0] m,
                     input logic [7:0] a, input logic g, input logic [21:0] pe, po,
                     input logic emc);
      logic seen;
      @(negedge clk_sys);
      {jw_req, jw_index, jw_vpn2, jw_mask, jw_asid, jw_global} = {1'b1, i, v, m, a, g};
      {jw_pfn_even, jw_pfn_odd} = {pe, po};
      @(negedge clk_sys);
      jw_req = 1'b0;
      seen = machine_check_reg;
      @(negedge clk_sys);
      seen = seen | machine_check_reg;
      chk("machine_check", {31'h0, emc}, {31'h0, seen});
   endtask
   task automatic t_seg;
      x(0, 32'h8000_1234, 32'h0000_1234, 1, 0);
      chk("f_uncached", 32'h0, {31'h0, fetch_uncached_reg});
      x(1, 32'ha000_5678, 32'h0000_5678, 1, 0);
      chk("d_uncached", 32'h1, {31'h0, data_uncached_reg});
      x(0, 32'hc000_0000, 32'h0, 2, 1);
      x(1, 32'h0040_0abc, 32'h0, 1, 1);
   endtask
   task automatic t_fill;
      jw(4'h0, 21'h00800, 18'h0, 8'h05, 0, 22'h001230, 22'h002000, 0);
      x(0, 32'h0040_0abc, 32'h0048_cabc, 3, 0);
      x(0, 32'h0040_0abc, 32'h0048_cabc, 1, 0);
      x(1, 32'h0040_1abc, 32'h0080_0abc, 2, 0);
      x(1, 32'h0040_1abc, 32'h0080_0abc, 1, 0);
   endtask
   task automatic t_asid;
      jw(4'h1, 21'h01000, 18'h0, 8'h07, 0, 22'h003000, 22'h003004, 0);
      x(1, 32'h0080_0010, 32'h0, 1, 1);
      current_entry_high_asid = 8'h07;
      x(1, 32'h0080_0010, 32'h00c0_0010, 2, 0);
      jw(4'h2, 21'h01800, 18'h0, 8'h99, 1, 22'h004000, 22'h004004, 0);
      x(0, 32'h00c0_0020, 32'h0100_0020, 3, 0);
   endtask
   task automatic t_wcmp;
      x(0, 32'h00c0_0020, 32'h0100_0020, 1, 0);
      jw(4'h3, 21'h00800, 18'h0, 8'h05, 0, 22'h3ff000, 22'h3ff000, 1);
      jw(4'h4, 21'h01ff0, 18'h0, 8'h05, 0, 22'h005000, 22'h005004, 0);
      x(0, 32'h00c0_0020, 32'h0100_0020, 3, 0);
      // granularity request must be ignored in a 4 Kbyte minimum build
      page_granularity_config = 1'b1;
      current_entry_high_asid = 8'h05;
      x(1, 32'h0040_0abc, 32'h0048_cabc, 2, 0);
   endtask
   task automatic t_big;
      jw(4'h5, 21'h80000, 18'h3ffff, 8'h00, 1, 22'h080000, 22'h0c0000, 0);
      x(0, 32'h5123_4567, 32'h3123_4567, 3, 0);
      x(0, 32'h5123_4567, 32'h3123_4567, 1, 0);
      x(0, 32'h5123_5567, 32'h3123_5567, 3, 0);
      x(1, 32'h4000_0010, 32'h2000_0010, 2, 0);
   endtask
   task automatic t_dbg;
      cur_mode = MODE_DEBUG;
      x(0, 32'hff30_0010, 32'hff30_0010, 1, 0);
      chk("to_debug", 32'h1, {31'h0, fetch_to_debug_reg});
      x(1, 32'hff20_0000, 32'hff20_0000, 1, 0);
      chk("d_to_debug", 32'h1, {31'h0, data_to_debug_reg});
      cur_mode = MODE_KERNEL;
      x(1, 32'hff30_0010, 32'h0, 1, 1);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(negedge clk_sys);
      sys_rst = 1'b0;
      t_seg();
      t_fill();
      t_asid();
      t_wcmp();
      t_big();
      t_dbg();
      results();
   end
endmodule
